/* File: hw/fdc_ctrl.sv */
// Floppy drive control signals with APB register access
`timescale 1ns/1ps

// Functional notes
// - Completion interrupt set on done, cleared by status read or command write
// - One step pulse per single track move
// - Direction high inward, low outward
// - Low halve input halves internal timing rate
// - Side output follows command side flag of read/write commands
// - ID side mismatch sets record missing bit
// - Side output changes only at command start
// - Side output zero during master reset
// - Head load output presses head on medium
// - Inner track output at track 44 onward
// - Inner track output valid during read/write
// - Test low routes internal signals to pins
// - Pump drives up/down, released when idle
// - Track register follows each step
// - Head engaged only while engaged input high
module fdc_ctrl
   import fdc_pkg::*;
#(
   parameter int RATE_CYC = STEP_RATE_CYC
) (
   // Clock and reset
   input  wire logic              pclk,
   input  wire logic              presetn,
   // APB slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   output logic [31:0]            prdata,
   output logic                   pready,
   output logic                   pslverr,
   // Interrupts
   output logic                   completion_irq,
   output logic                   irq,
   // Drive pins
   output logic                   step_out,
   output logic                   head_direction,
   output logic                   side_select_out,
   output logic                   head_load_out,
   output logic                   inner_track_out,
   input  wire logic              head_engaged_in,
   input  wire logic              raw_flux_n,
   input  wire logic              mini_clock_halve_n,
   input  wire logic              test_n,
   // Data separator pump
   input  wire logic              pump_up,
   input  wire logic              pump_down,
   output logic                   pump_out,
   output logic                   pump_oe,
   // ID field checker
   input  wire logic              id_side_valid,
   input  wire logic              id_side
);

   typedef enum logic [2:0] {
      FDC_IDLE,
      FDC_STEP,
      FDC_STEP_WAIT,
      FDC_HEAD_WAIT,
      FDC_ID_WAIT,
      FDC_FINISH
   } fdc_state_type;

   // --------
   // Pin synchronisers and internal timing enable
   // --------
   logic [1:0] halve_s_q, engaged_s_q, flux_s_q, test_s_q;
   logic       flux_d1_q;
   logic       half_q;

   // Two flops per pin; only the second stage is read
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         halve_s_q   <= 2'h3;
         engaged_s_q <= 2'h0;
         flux_s_q    <= 2'h3;
         test_s_q    <= 2'h3;
         flux_d1_q   <= 1'b1;
         half_q      <= 1'b0;
      end else begin
         halve_s_q   <= {halve_s_q[0], mini_clock_halve_n};
         engaged_s_q <= {engaged_s_q[0], head_engaged_in};
         flux_s_q    <= {flux_s_q[0], raw_flux_n};
         test_s_q    <= {test_s_q[0], test_n};
         flux_d1_q   <= flux_s_q[1];
         half_q      <= ~half_q;
      end
   end

   wire halve_on   = ~halve_s_q[1];
   wire engaged    = engaged_s_q[1];
   wire test_on    = ~test_s_q[1];
   wire flux_fall  = flux_d1_q & ~flux_s_q[1];
   wire tick       = halve_on ? half_q : 1'b1;

   // --------
   // APB decode
   // --------
   logic        pready_q, pslverr_q;
   logic [31:0] prdata_q;

   wire access   = psel & penable & ~pready_q;
   wire commit   = psel & penable & pready_q;
   wire hit_cmd  = (paddr == ADDR_CMD);
   wire hit_stat = (paddr == ADDR_STATUS);
   wire hit_trk  = (paddr == ADDR_TRACK);
   wire hit_ctrl = (paddr == ADDR_CTRL);
   wire hit_ist  = (paddr == ADDR_IRQ_STAT);
   wire hit_iclr = (paddr == ADDR_IRQ_CLR);
   wire hit_ien  = (paddr == ADDR_IRQ_EN);
   wire hit_flux = (paddr == ADDR_FLUX);
   wire mapped   = hit_cmd | hit_stat | hit_trk | hit_ctrl | hit_ist
                 | hit_iclr | hit_ien | hit_flux;
   wire wr_ok    = commit & pwrite & mapped;
   wire rd_ok    = commit & ~pwrite & mapped;
   wire wr_cmd   = wr_ok & hit_cmd;
   wire rd_stat  = rd_ok & hit_stat;

   // --------
   // Sequencer state
   // --------
   fdc_state_type state_q;
   fdc_op_type    op_q;
   logic [7:0]    track_q, steps_q, flux_cnt_q;
   logic          side_q, rnf_q, irq_done_q, hold_q, head_load_q;
   logic          inner_q, pump_q, pump_oe_q, irq_q;
   logic [EV_NUM-1:0] ist_q, ien_q;
   logic          done_ev, rnf_ev;

   fdc_step_if sif ();

   fdc_stepper #(
      .RATE_CYC (RATE_CYC)
   ) u_stepper (
      .pclk    (pclk),
      .presetn (presetn),
      .sif     (sif)
   );

   wire        busy     = (state_q != FDC_IDLE);
   wire [1:0]  cmd_op   = pwdata[CMD_OP_LSB +: 2];
   wire        is_xfer  = (op_q == FDC_OP_READ) | (op_q == FDC_OP_WRITE);
   wire        at_inner = (track_q >= INNER_TRACK);
   wire        mismatch = id_side_valid & (id_side != side_q);

   assign sif.tick   = tick;
   assign sif.inward = (op_q == FDC_OP_STEP_IN);
   assign sif.start  = (state_q == FDC_STEP) & (steps_q != '0);
   assign done_ev    = (state_q == FDC_FINISH);
   assign rnf_ev     = (state_q == FDC_ID_WAIT) & mismatch;

   // Command sequencer: steps, side, head load, ID side compare
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q     <= FDC_IDLE;
         op_q        <= FDC_OP_STEP_IN;
         steps_q     <= '0;
         track_q     <= TRACK_RST;
         side_q      <= 1'b0;
         rnf_q       <= 1'b0;
         head_load_q <= 1'b0;
      end else begin
         case (state_q)
            FDC_IDLE: begin
               if (wr_cmd) begin
                  op_q    <= fdc_op_type'(cmd_op);
                  steps_q <= pwdata[CMD_CNT_LSB +: 8];
                  rnf_q   <= 1'b0;
                  if (cmd_op == FDC_OP_READ || cmd_op == FDC_OP_WRITE) begin
                     side_q      <= pwdata[CMD_SIDE_BIT];
                     head_load_q <= 1'b1;
                     state_q     <= FDC_HEAD_WAIT;
                  end else begin
                     state_q <= FDC_STEP;
                  end
               end else begin
                  head_load_q <= hold_q;
               end
            end
            FDC_STEP: begin
               state_q <= (steps_q == '0) ? FDC_FINISH : FDC_STEP_WAIT;
            end
            FDC_STEP_WAIT: begin
               if (sif.done) begin
                  // Track register follows the head, one per step
                  if (op_q == FDC_OP_STEP_IN) begin
                     track_q <= track_q + 1'b1;
                  end else begin
                     track_q <= track_q - 1'b1;
                  end
                  steps_q <= steps_q - 1'b1;
                  state_q <= FDC_STEP;
               end
            end
            FDC_HEAD_WAIT: begin
               if (engaged) begin
                  state_q <= FDC_ID_WAIT;
               end
            end
            FDC_ID_WAIT: begin
               if (id_side_valid) begin
                  rnf_q   <= mismatch;
                  state_q <= FDC_FINISH;
               end
            end
            default: begin
               state_q <= FDC_IDLE;
            end
         endcase
         // Track register written by software only while idle
         if (wr_ok && hit_trk && !busy) begin
            track_q <= pwdata[7:0];
         end
      end
   end

   // Completion flag, interrupt status and enables
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_done_q <= 1'b0;
         ist_q      <= '0;
         ien_q      <= '0;
         irq_q      <= 1'b0;
         hold_q     <= 1'b0;
         flux_cnt_q <= '0;
      end else begin
         // Completion wins over a clearing access in the same cycle
         irq_done_q <= done_ev | (irq_done_q & ~(rd_stat | wr_cmd));
         ist_q[EV_DONE] <= done_ev
                         | (ist_q[EV_DONE] & ~(wr_ok & hit_iclr
                                             & pwdata[EV_DONE]));
         ist_q[EV_RNF]  <= rnf_ev
                         | (ist_q[EV_RNF] & ~(wr_ok & hit_iclr
                                            & pwdata[EV_RNF]));
         if (wr_ok && hit_ien) begin
            ien_q <= pwdata[EV_NUM-1:0];
         end
         if (wr_ok && hit_ctrl) begin
            hold_q <= pwdata[CTRL_HOLD_BIT];
         end
         irq_q <= |(ist_q & ien_q);
         if (flux_fall) begin
            flux_cnt_q <= flux_cnt_q + 1'b1;
         end
      end
   end

   // --------
   // Drive side outputs: inner track, pump, test routing
   // --------
   wire inner_d   = test_on ? tick : (at_inner & is_xfer & busy);
   wire pump_on_d = test_on | (pump_up ^ pump_down);

   // Registered pins; test mode shows internal timing and pump demand
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         inner_q   <= 1'b0;
         pump_q    <= 1'b0;
         pump_oe_q <= 1'b0;
      end else begin
         inner_q   <= inner_d;
         pump_q    <= pump_up;
         pump_oe_q <= pump_on_d;
      end
   end

   // --------
   // APB answer: one wait state, registered data and error
   // --------
   logic [31:0] rd_mux;

   always_comb begin
      rd_mux = RDATA_ZERO;
      if (hit_stat) begin
         rd_mux[STAT_BUSY_BIT] = busy;
         rd_mux[STAT_RNF_BIT]  = rnf_q;
         rd_mux[STAT_HEAD_BIT] = engaged;
         rd_mux[STAT_SIDE_BIT] = side_q;
         rd_mux[STAT_IRQ_BIT]  = irq_done_q;
      end else if (hit_trk) begin
         rd_mux[7:0] = track_q;
      end else if (hit_ctrl) begin
         rd_mux[CTRL_HOLD_BIT] = hold_q;
      end else if (hit_ist) begin
         rd_mux[EV_NUM-1:0] = ist_q;
      end else if (hit_ien) begin
         rd_mux[EV_NUM-1:0] = ien_q;
      end else if (hit_flux) begin
         rd_mux[7:0] = flux_cnt_q;
      end
   end

   // Ready rises on the second access cycle for every transfer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= RDATA_ZERO;
      end else begin
         pready_q  <= access;
         pslverr_q <= access & ~mapped;
         if (access && !pwrite) begin
            prdata_q <= rd_mux;
         end
      end
   end

   // --------
   // Output connections
   // --------
   assign prdata          = prdata_q;
   assign pready          = pready_q;
   assign pslverr         = pslverr_q;
   assign completion_irq  = irq_done_q;
   assign irq             = irq_q;
   assign step_out        = sif.step;
   assign head_direction  = sif.dir;
   assign side_select_out = side_q;
   assign head_load_out   = head_load_q;
   assign inner_track_out = inner_q;
   assign pump_out        = pump_q;
   assign pump_oe         = pump_oe_q;

endmodule

/* File: include/fdc_pkg.sv */
// Shared constants and types of the floppy drive control block
package fdc_pkg;

   // --------
   // Register map (byte addresses)
   // --------
   localparam int          ADDR_W        = 8;
   localparam logic [7:0]  ADDR_CMD      = 8'h00;
   localparam logic [7:0]  ADDR_STATUS   = 8'h04;
   localparam logic [7:0]  ADDR_TRACK    = 8'h08;
   localparam logic [7:0]  ADDR_CTRL     = 8'h0C;
   localparam logic [7:0]  ADDR_IRQ_STAT = 8'h10;
   localparam logic [7:0]  ADDR_IRQ_CLR  = 8'h14;
   localparam logic [7:0]  ADDR_IRQ_EN   = 8'h18;
   localparam logic [7:0]  ADDR_FLUX     = 8'h1C;

   // --------
   // Field layouts and reset values
   // --------
   localparam int          CMD_OP_LSB    = 0;
   localparam int          CMD_SIDE_BIT  = 3;
   localparam int          CMD_CNT_LSB   = 8;
   localparam int          STAT_BUSY_BIT = 0;
   localparam int          STAT_RNF_BIT  = 4;
   localparam int          STAT_HEAD_BIT = 5;
   localparam int          STAT_SIDE_BIT = 6;
   localparam int          STAT_IRQ_BIT  = 7;
   localparam int          CTRL_HOLD_BIT = 0;
   localparam int          EV_DONE       = 0;
   localparam int          EV_RNF        = 1;
   localparam int          EV_NUM        = 2;
   localparam logic [7:0]  TRACK_RST     = 8'h00;
   localparam logic [7:0]  INNER_TRACK   = 8'h2C;
   localparam logic [31:0] RDATA_ZERO    = 32'h0000_0000;

   // --------
   // Command codes
   // --------
   typedef enum logic [1:0] {
      FDC_OP_STEP_IN,
      FDC_OP_STEP_OUT,
      FDC_OP_READ,
      FDC_OP_WRITE
   } fdc_op_type;

   // --------
   // Timing
   // --------
   localparam int CLK_MHZ       = 125;
   localparam int DIR_SETUP_NS  = 1000;
   localparam int STEP_PULSE_NS = 4000;
   localparam int STEP_RATE_US  = 6000;
   localparam int DIR_SETUP_CYC = (DIR_SETUP_NS * CLK_MHZ + 999) / 1000;
   localparam int STEP_PULSE_CYC = (STEP_PULSE_NS * CLK_MHZ + 999) / 1000;
   localparam int STEP_RATE_CYC = STEP_RATE_US * CLK_MHZ;
   localparam int TICK_W        = 20;

endpackage

/* File: include/fdc_step_if.sv */
// Signals between the command sequencer and the step pulse generator
`timescale 1ns/1ps
interface fdc_step_if;
   logic tick;    // Internal timing enable
   logic start;   // One-cycle request for one step
   logic inward;  // Direction of the requested step
   logic busy;    // Step in progress
   logic done;    // One-cycle pulse when the step has finished
   logic step;    // Step pin level
   logic dir;     // Direction pin level

   modport ctrl    (output tick, start, inward,
                    input  busy, done, step, dir);
   modport stepper (input  tick, start, inward,
                    output busy, done, step, dir);
endinterface

/* File: hw/fdc_stepper.sv */
// Step pulse generator with direction setup and step rate wait
`timescale 1ns/1ps
module fdc_stepper
   import fdc_pkg::*;
#(
   parameter int RATE_CYC = STEP_RATE_CYC
) (
   // Clock and reset
   input wire logic     pclk,
   input wire logic     presetn,
   // Sequencer side
   fdc_step_if.stepper  sif
);

   typedef enum logic [1:0] {
      FDC_ST_IDLE,
      FDC_ST_SETUP,
      FDC_ST_PULSE,
      FDC_ST_RATE
   } fdc_st_type;

   localparam logic [TICK_W-1:0] SETUP_LAST = TICK_W'(DIR_SETUP_CYC - 1);
   localparam logic [TICK_W-1:0] PULSE_LAST = TICK_W'(STEP_PULSE_CYC - 1);
   localparam logic [TICK_W-1:0] RATE_LAST  = TICK_W'(RATE_CYC - 1);

   fdc_st_type        st_q;
   logic [TICK_W-1:0] cnt_q;
   logic              step_q;
   logic              dir_q;
   logic              done_q;
   wire               cnt_end = (cnt_q == '0);

   assign sif.step = step_q;
   assign sif.dir  = dir_q;
   assign sif.done = done_q;
   assign sif.busy = (st_q != FDC_ST_IDLE);

   // Direction settles, one pulse, then the step rate wait
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q   <= FDC_ST_IDLE;
         cnt_q  <= '0;
         step_q <= 1'b0;
         dir_q  <= 1'b0;
         done_q <= 1'b0;
      end else begin
         done_q <= 1'b0;
         case (st_q)
            FDC_ST_IDLE: begin
               if (sif.start) begin
                  dir_q <= sif.inward;
                  cnt_q <= SETUP_LAST;
                  st_q  <= FDC_ST_SETUP;
               end
            end
            FDC_ST_SETUP: begin
               if (sif.tick && cnt_end) begin
                  step_q <= 1'b1;
                  cnt_q  <= PULSE_LAST;
                  st_q   <= FDC_ST_PULSE;
               end else if (sif.tick) begin
                  cnt_q <= cnt_q - 1'b1;
               end
            end
            FDC_ST_PULSE: begin
               if (sif.tick && cnt_end) begin
                  step_q <= 1'b0;
                  cnt_q  <= RATE_LAST;
                  st_q   <= FDC_ST_RATE;
               end else if (sif.tick) begin
                  cnt_q <= cnt_q - 1'b1;
               end
            end
            default: begin
               if (sif.tick && cnt_end) begin
                  done_q <= 1'b1;
                  st_q   <= FDC_ST_IDLE;
               end else if (sif.tick) begin
                  cnt_q <= cnt_q - 1'b1;
               end
            end
         endcase
      end
   end

endmodule

/* File: tb/fdc_ctrl_checker.sv */
// Port level assertions for the floppy drive control block
`timescale 1ns/1ps
module fdc_ctrl_checker
   import fdc_pkg::*;
(
   // Clock and reset
   input wire logic              pclk,
   input wire logic              presetn,
   // APB
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic              pready,
   input wire logic              pslverr,
   // Drive side
   input wire logic              completion_irq,
   input wire logic              step_out,
   input wire logic              head_direction,
   input wire logic              side_select_out,
   input wire logic              test_n,
   input wire logic              pump_up,
   input wire logic              pump_down,
   input wire logic              pump_out,
   input wire logic              pump_oe
);
   // --------
   // Helper logic
   // --------
   logic [11:0] hi_cnt_q;
   wire         acc_done = psel && penable && pready;
   wire         wr_cmd   = acc_done && pwrite && (paddr == ADDR_CMD);
   wire         clr_acc  = acc_done && (pwrite ? paddr == ADDR_CMD
                                               : paddr == ADDR_STATUS);

   // Cycles the step pin has been high so far
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         hi_cnt_q <= 12'h000;
      else
         hi_cnt_q <= step_out ? hi_cnt_q + 12'h001 : 12'h000;
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // --------
   // Assertions
   // --------
   a_ready_wait: assert property (psel && penable && !pready |=> pready)
      else $error("pready late after access cycle");
   a_ready_cause: assert property (pready |-> $past(psel && penable && !pready))
      else $error("pready without access");
   a_err_ready: assert property (pslverr |-> pready)
      else $error("pslverr outside pready");
   a_irq_clear: assert property ($fell(completion_irq) |-> $past(clr_acc))
      else $error("completion irq dropped without clear");
   a_dir_hold: assert property (step_out |-> $stable(head_direction))
      else $error("direction moved during step pulse");
   a_step_width: assert property ($fell(step_out) |->
      hi_cnt_q == STEP_PULSE_CYC || hi_cnt_q == 2 * STEP_PULSE_CYC)
      else $error("step pulse width wrong");
   a_side_change: assert property ($changed(side_select_out) |-> $past(wr_cmd))
      else $error("side select moved outside command");
   a_side_reset: assert property ($rose(presetn) |-> !side_select_out)
      else $error("side select not zero out of reset");
   a_pump_drive: assert property ($past(pump_up) != $past(pump_down) |->
      pump_oe && pump_out == $past(pump_up))
      else $error("pump not driven on request");
   a_pump_release: assert property ($past(pump_up) == $past(pump_down) &&
      test_n && $past(test_n, 2) && $past(test_n, 4) |-> !pump_oe)
      else $error("pump driven while idle");

   c_cmd: cover property (wr_cmd);
   c_step: cover property ($fell(step_out));
   c_err: cover property (pslverr);
   c_pump: cover property (pump_oe && test_n);
endmodule

bind fdc_ctrl fdc_ctrl_checker u_chk (.pclk, .presetn, .psel, .penable, .pwrite,
   .paddr, .pready, .pslverr, .completion_irq, .step_out, .head_direction,
   .side_select_out, .test_n, .pump_up, .pump_down, .pump_out, .pump_oe);

/* File: tb/fdc_drive_model.sv */
// Behavioural floppy drive facing the controller's drive pins
`timescale 1ns/1ps
module fdc_drive_model #(
   parameter int ENGAGE_CYC = 40
) (
   // Clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // From the controller
   input  wire logic step_out,
   input  wire logic head_direction,
   input  wire logic head_load_out,
   // To the controller
   output logic      head_engaged_in,
   output logic      raw_flux_n,
   output logic      id_side_valid,
   output logic      id_side,
   // Bench view
   input  wire logic disk_side,
   output int        track_pos,
   output int        flux_seen
);
   int   load_t;
   logic step_d;

   // Head settle one-shot, flux stream and ID side field
   assign head_engaged_in = load_t >= ENGAGE_CYC;
   assign raw_flux_n      = !(head_engaged_in && load_t[3:1] == 3'h7);
   assign id_side_valid   = load_t == ENGAGE_CYC + 20;
   assign id_side         = id_side_valid ? disk_side : !disk_side;

   // Load timer, head position follower and flux count
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         load_t <= 0;
         step_d <= 1'b0;
         track_pos <= 0;
         flux_seen <= 0;
      end else begin
         step_d <= step_out;
         load_t <= head_load_out ? load_t + 1 : 0;
         if (step_out && !step_d)
            track_pos <= track_pos + (head_direction ? 1 : -1);
         if (head_engaged_in && load_t[3:0] == 4'hE)
            flux_seen <= flux_seen + 1;
      end
   end
endmodule

/* File: tb/test_fdc_ctrl.sv */
// Self-checking bench of the floppy drive control block
`timescale 1ns/1ps
module test_fdc_ctrl import fdc_pkg::*; ;
   localparam int RATE = 20;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata;
   logic        completion_irq, irq, step_out, head_direction;
   logic        side_select_out, head_load_out, inner_track_out;
   logic        head_engaged_in, raw_flux_n, mini_clock_halve_n, test_n;
   logic        pump_up, pump_down, pump_out, pump_oe;
   logic        id_side_valid, id_side, disk_side;
   int          track_pos, flux_seen, n_mismatch, samples_checked;
   int          hi_cyc, t0, trk, n, cnt;
   typedef struct {logic [31:0] e; logic [31:0] m; logic r;} fdc_note_type;
   fdc_note_type notes[$];
   fdc_note_type nt;
   logic [7:0]  rst_addr[6] = '{ADDR_STATUS, ADDR_TRACK, ADDR_CTRL,
                                ADDR_IRQ_STAT, ADDR_IRQ_EN, ADDR_FLUX};

   fdc_ctrl #(.RATE_CYC(RATE)) uut (.pclk, .presetn, .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .completion_irq,
      .irq, .step_out, .head_direction, .side_select_out, .head_load_out,
      .inner_track_out, .head_engaged_in, .raw_flux_n, .mini_clock_halve_n,
      .test_n, .pump_up, .pump_down, .pump_out, .pump_oe, .id_side_valid,
      .id_side);
   fdc_drive_model #(.ENGAGE_CYC(40)) drive (.pclk, .presetn, .step_out,
      .head_direction, .head_load_out, .head_engaged_in, .raw_flux_n,
      .id_side_valid, .id_side, .disk_side, .track_pos, .flux_seen);

   // --------
   // Clock, checks and verdict
   // --------
   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end

   task automatic give_verdict;
      $display("mismatches %0d comparisons %0d", n_mismatch, samples_checked);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      samples_checked++;
      if (s !== e) begin
         $display("[ERR] %s expected %h seen %h", nm, e, s);
         n_mismatch++;
      end
   endtask

   task automatic chkb(input string nm, input logic e, input logic s);
      chk(nm, {31'h0, e}, {31'h0, s});
   endtask

   // Takes the oldest note at each completed transfer
   always @(posedge pclk) begin
      if (psel && penable && pready === 1'b1 && notes.size() > 0) begin
         nt = notes.pop_front();
         chk("prdata", nt.e, prdata & nt.m);
         chkb("pslverr", nt.r, pslverr);
      end
   end

   // Counts cycles with the step pin high
   always @(posedge pclk) if (step_out === 1'b1) hi_cyc++;

   // --------
   // Bus and wait tasks
   // --------
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [31:0] e, input logic [31:0] m, input logic r);
      int k;
      notes.push_back('{e, m, r});
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      if (k >= 50) begin
         n_mismatch++;
         give_verdict;
      end
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 32'h0, 32'h0, 1'b0);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
      apb(1'b0, a, 32'h0, e, m, 1'b0);
   endtask

   task automatic wait_done;
      int k;
      k = 0;
      while (completion_irq !== 1'b1 && k < 20000) begin
         @(posedge pclk);
         k++;
      end
      if (k >= 20000) begin
         n_mismatch++;
         give_verdict;
      end
   endtask

   // --------
   // Main sequence
   // --------
   initial begin
      {psel, penable, pwrite, pump_up, pump_down, disk_side} = 6'h00;
      paddr = 8'h00;
      pwdata = 32'h0;
      presetn = 1'b0;
      mini_clock_halve_n = 1'b1;
      test_n = 1'b1;
      n_mismatch = 0;
      samples_checked = 0;
      hi_cyc = 0;
      void'($urandom(24));
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      foreach (rst_addr[i]) rd(rst_addr[i], 32'h0, 32'hFFFF_FFFF);
      apb(1'b0, 8'h20, 32'h0, 32'h0, 32'hFFFF_FFFF, 1'b1);
      apb(1'b1, 8'h24, 32'h5, 32'h0, 32'h0, 1'b1);
      n = $urandom_range(10, 40);
      wr(ADDR_TRACK, n);
      rd(ADDR_TRACK, n, 32'hFF);
      wr(ADDR_IRQ_EN, 32'h3);
      rd(ADDR_IRQ_EN, 32'h3, 32'h3);
      wr(ADDR_CTRL, 32'h1);
      repeat (2) @(posedge pclk);
      chkb("head_load_out", 1'b1, head_load_out);
      wr(ADDR_CTRL, 32'h0);
      // Read at track 43 on side 0, write at track 44 on side 1
      for (int i = 0; i < 2; i++) begin
         wr(ADDR_TRACK, 32'd43 + i);
         wr(ADDR_CMD, {28'h0, i[0], 1'b0, i[0] ? FDC_OP_WRITE : FDC_OP_READ});
         repeat (2) @(posedge pclk);
         chkb("completion_irq", 1'b0, completion_irq);
         chkb("side_select_out", i[0], side_select_out);
         repeat (50) @(posedge pclk);
         chkb("inner_track_out", i[0], inner_track_out);
         chkb("head_load_out", 1'b1, head_load_out);
         wait_done;
         repeat (2) @(posedge pclk);
         chkb("irq", 1'b1, irq);
         rd(ADDR_STATUS, {24'h0, 3'h4, i[0], 4'h0}, 32'h91);
         chkb("completion_irq", 1'b0, completion_irq);
         rd(ADDR_IRQ_STAT, {30'h0, i[0], 1'b1}, 32'h3);
         wr(ADDR_IRQ_CLR, 32'h3);
         repeat (2) @(posedge pclk);
         chkb("irq", 1'b0, irq);
      end
      repeat (4) @(posedge pclk);
      rd(ADDR_FLUX, flux_seen & 32'hFF, 32'hFF);
      trk = 44;
      // Three steps in at full rate, two steps out with halved timing
      for (int j = 0; j < 2; j++) begin
         mini_clock_halve_n <= !j[0];
         n = 3 - j;
         t0 = track_pos;
         hi_cyc = 0;
         wr(ADDR_CMD, {16'h0, n[7:0], 6'h0, j[0] ? FDC_OP_STEP_OUT : FDC_OP_STEP_IN});
         if (j == 0) begin
            wr(ADDR_CMD, 32'h0000_0500);
            wr(ADDR_TRACK, 32'h0);
         end
         wait_done;
         chk("step_high", n * STEP_PULSE_CYC * (j + 1), hi_cyc);
         chk("steps", j ? -n : n, track_pos - t0);
         chkb("head_direction", !j[0], head_direction);
         chkb("side_select_out", 1'b1, side_select_out);
         trk = trk + (j ? -n : n);
         rd(ADDR_TRACK, trk, 32'hFF);
         rd(ADDR_STATUS, 32'h80, 32'h81);
      end
      // Test mode routing and random pump requests
      cnt = 0;
      test_n <= 1'b0;
      for (int k = 0; k < 120; k++) begin
         @(posedge pclk);
         {pump_up, pump_down} <= 2'($urandom);
         if (k == 60)
            test_n <= 1'b1;
         if (k > 4 && k < 60 && inner_track_out === 1'b1)
            cnt++;
         if (k == 58)
            chkb("pump_oe", 1'b1, pump_oe);
      end
      chkb("test_route", 1'b1, cnt > 20 && cnt < 35);
      {pump_up, pump_down} <= 2'h0;
      repeat (3) @(posedge pclk);
      chkb("pump_oe", 1'b0, pump_oe);
      presetn <= 1'b0;
      @(posedge pclk);
      chkb("side_select_out", 1'b0, side_select_out);
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(ADDR_TRACK, TRACK_RST, 32'hFF);
      give_verdict;
   end
endmodule
